// *** core/tatf_top.sv ***
// tatf_top: temperature reading trim and overtemperature fault flag
// assumes: register port, reading and unlock level come from logic
// on i_clock; the unlock source lives outside this block
//
// Operation
// [RQ1] writes to offset and gain trims are dropped unless unlocked.
// [RQ2] offset magnitude is high bit 0 above all eight low bits.
// [RQ3] high register bit 1 set makes the offset negative.
// [RQ4] every reading is offset-corrected before compare and report.
// [RQ5] gain register bits 6..0 give the gain correction magnitude.
// [RQ6] gain register bit 7 set makes the gain correction negative.
// [RQ7] the 8-bit threshold becomes 9 bits against reading bits 11..3.
// [RQ8] a reading below the threshold raises the fault condition.
// [RQ9] the condition must last 100 ms before the flag sets.
// [RQ10] one threshold step is 3.125 mV, 256 steps over 0 to 800 mV.
// [RQ11] software keeps threshold codes between 9.375 and 781.25 mV.
// [RQ12] the debounce count restarts when the condition drops early.
// [RQ13] the threshold gains a low zero; high trim spare bits store.
`include "tatf_defs.svh"

module tatf_top #(
    parameter int unsigned DEBOUNCE_CYCLES =
        int'(`TATF_DEBOUNCE_CYCLES)
) (
    // clock, reset, enable
    input  wire logic                    i_clock,
    input  wire logic                    i_reset,
    input  wire logic                    i_clock_enable,
    // register port
    input  wire logic                    i_reg_write,
    input  wire logic                    i_reg_read,
    input  wire logic [15:0]             i_reg_addr,
    input  wire logic [7:0]              i_reg_wdata,
    output logic [7:0]                   o_reg_rdata,
    output logic                         o_reg_rvalid,
    output logic                         o_write_refused,
    // trim write lock
    input  wire logic                    i_trim_unlock,
    // converter reading
    input  wire logic                    i_adc_valid,
    input  wire tatf_pkg::tatf_reading_t i_adc_data,
    // corrected reading and fault
    output logic                         o_temp_valid,
    output tatf_pkg::tatf_reading_t      o_temp_value,
    output logic                         o_overtemp_fault
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [7:0]              ofs_high_reg;
    logic [7:0]              ofs_low_reg;
    logic [7:0]              gain_reg;
    logic [7:0]              thresh_reg;
    logic                    hit_ofs_high;
    logic                    hit_ofs_low;
    logic                    hit_gain;
    logic                    hit_thresh;
    logic                    hit_status;
    logic                    trim_hit;
    logic                    trim_write_ok;
    logic [8:0]              offset_mag;
    logic [8:0]              thresh_9;
    logic                    corr_valid;
    tatf_pkg::tatf_reading_t corr_value;
    logic                    below_reg;
    logic                    seen_reg;
    logic                    fault_flag;
    logic [7:0]              rdata_next;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    assign hit_ofs_high = (i_reg_addr == `TATF_ADDR_OFS_HIGH);
    assign hit_ofs_low  = (i_reg_addr == `TATF_ADDR_OFS_LOW);
    assign hit_gain     = (i_reg_addr == `TATF_ADDR_GAIN);
    assign hit_thresh   = (i_reg_addr == `TATF_ADDR_THRESH);
    assign hit_status   = (i_reg_addr == `TATF_ADDR_STATUS);

    // trim registers only accept writes while the lock is released
    assign trim_hit      = hit_ofs_high | hit_ofs_low | hit_gain;
    assign trim_write_ok = i_reg_write & trim_hit & i_trim_unlock; // RQ1

    // ----------------------------------------------------------------
    // offset trim, high part
    // ----------------------------------------------------------------
    // spare bits 7..2 hold what was written
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ofs_high_reg <= `TATF_REG_RESET;
        end else if (i_clock_enable) begin
            if (trim_write_ok && hit_ofs_high) begin // RQ1
                ofs_high_reg <= i_reg_wdata; // RQ13
            end
        end
    end

    // ----------------------------------------------------------------
    // offset trim, low part
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ofs_low_reg <= `TATF_REG_RESET;
        end else if (i_clock_enable) begin
            if (trim_write_ok && hit_ofs_low) begin // RQ1
                ofs_low_reg <= i_reg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // gain trim
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            gain_reg <= `TATF_REG_RESET;
        end else if (i_clock_enable) begin
            if (trim_write_ok && hit_gain) begin // RQ1
                gain_reg <= i_reg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // fault threshold, not locked
    // ----------------------------------------------------------------
    // each code step stands for 3.125 mV of sensed voltage
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            thresh_reg <= `TATF_REG_RESET;
        end else if (i_clock_enable) begin
            if (i_reg_write && hit_thresh) begin // RQ10
                thresh_reg <= i_reg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // refused write indication
    // ----------------------------------------------------------------
    // one-cycle pulse when a trim write is dropped by the lock
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_write_refused <= 1'b0;
        end else if (i_clock_enable) begin
            o_write_refused <= i_reg_write & trim_hit
                               & ~i_trim_unlock; // RQ1
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        rdata_next = `TATF_READ_UNMAPPED;
        if (hit_ofs_high) begin
            rdata_next = ofs_high_reg; // RQ13
        end else if (hit_ofs_low) begin
            rdata_next = ofs_low_reg;
        end else if (hit_gain) begin
            rdata_next = gain_reg;
        end else if (hit_thresh) begin
            rdata_next = thresh_reg;
        end else if (hit_status) begin
            rdata_next[`TATF_STATUS_FAULT] = fault_flag;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else if (i_clock_enable) begin
            o_reg_rvalid <= i_reg_read;
            if (i_reg_read) begin
                o_reg_rdata <= rdata_next;
            end
        end
    end

    // ----------------------------------------------------------------
    // trim field assembly
    // ----------------------------------------------------------------
    assign offset_mag = {ofs_high_reg[`TATF_OFS_MSB_BIT],
                         ofs_low_reg}; // RQ2

    // ----------------------------------------------------------------
    // reading correction
    // ----------------------------------------------------------------
    tatf_trim u_trim (
        .i_clock        (i_clock),
        .i_reset        (i_reset),
        .i_clock_enable (i_clock_enable),
        .i_raw_valid    (i_adc_valid),
        .i_raw          (i_adc_data),
        .i_offset_mag   (offset_mag),
        .i_offset_neg   (ofs_high_reg[`TATF_OFS_NEG_BIT]),
        .i_gain_mag     (gain_reg[`TATF_GAIN_MAG_HI:0]),
        .i_gain_neg     (gain_reg[`TATF_GAIN_NEG_BIT]),
        .o_valid        (corr_valid),
        .o_value        (corr_value)
    );

    // ----------------------------------------------------------------
    // corrected reading report
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_temp_valid <= 1'b0;
            o_temp_value <= 12'h000;
        end else if (i_clock_enable) begin
            o_temp_valid <= corr_valid;
            if (corr_valid) begin
                o_temp_value <= corr_value; // RQ4
            end
        end
    end

    // ----------------------------------------------------------------
    // threshold compare
    // ----------------------------------------------------------------
    // low zero appended below the 8-bit field
    assign thresh_9 = {thresh_reg, 1'b0}; // RQ13

    // compare only once a corrected reading exists
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            seen_reg <= 1'b0;
        end else if (i_clock_enable) begin
            if (corr_valid) begin
                seen_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            below_reg <= 1'b0;
        end else if (i_clock_enable) begin
            below_reg <= seen_reg &&
                         (o_temp_value[11:3] < thresh_9); // RQ7 RQ8
        end
    end

    // ----------------------------------------------------------------
    // fault debounce
    // ----------------------------------------------------------------
    tatf_debounce #(
        .CYCLES (DEBOUNCE_CYCLES)
    ) u_debounce (
        .i_clock        (i_clock),
        .i_reset        (i_reset),
        .i_clock_enable (i_clock_enable),
        .i_condition    (below_reg),
        .o_flag         (fault_flag)
    );

    // ----------------------------------------------------------------
    // fault output
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_overtemp_fault <= 1'b0;
        end else if (i_clock_enable) begin
            o_overtemp_fault <= fault_flag; // RQ9
        end
    end

endmodule : tatf_top

// *** core/tatf_defs.svh ***
// tatf_defs.svh: offsets, field positions, reset values, timing counts
// assumes: included by bare name from every design file that needs it
`ifndef TATF_DEFS_SVH
`define TATF_DEFS_SVH

// --------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------
`define TATF_ADDR_OFS_HIGH   16'hFE16
`define TATF_ADDR_OFS_LOW    16'hFE17
`define TATF_ADDR_GAIN       16'hFE18
`define TATF_ADDR_THRESH     16'hFE19
`define TATF_ADDR_STATUS     16'hFE1F

// --------------------------------------------------------------------
// field positions and reset values
// --------------------------------------------------------------------
`define TATF_OFS_MSB_BIT     0
`define TATF_OFS_NEG_BIT     1
`define TATF_GAIN_NEG_BIT    7
`define TATF_GAIN_MAG_HI     6
`define TATF_STATUS_FAULT    0
`define TATF_REG_RESET       8'h00
`define TATF_READ_UNMAPPED   8'h00

// --------------------------------------------------------------------
// datapath sizes and scaling
// --------------------------------------------------------------------
`define TATF_ADC_W           12
`define TATF_GAIN_SHIFT      10
`define TATF_ADC_MAX         12'hFFF

// --------------------------------------------------------------------
// timing: debounce time in ms, clock in Hz, derived cycle count
// --------------------------------------------------------------------
`define TATF_DEBOUNCE_MS     64'd100
`define TATF_CLOCK_HZ        64'd40000000
`define TATF_DEBOUNCE_CYCLES \
    ((`TATF_DEBOUNCE_MS * `TATF_CLOCK_HZ) / 64'd1000)

`endif

// *** core/tatf_pkg.sv ***
// tatf_pkg: types shared by the overtemperature readout block
// assumes: compiled before every other design file
package tatf_pkg;

    // debounce state, one-hot
    typedef enum logic [2:0] {
        TATF_DB_IDLE  = 3'h1,
        TATF_DB_COUNT = 3'h2,
        TATF_DB_FAULT = 3'h4
    } tatf_db_state_t;

    typedef logic [11:0] tatf_reading_t;

endpackage : tatf_pkg

// *** core/tatf_trim.sv ***
// tatf_trim: gain and offset correction of one converter reading
// assumes: reading and trims come from logic on the same clock
`include "tatf_defs.svh"

module tatf_trim (
    // clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_reset,
    input  wire logic                  i_clock_enable,
    // raw reading
    input  wire logic                  i_raw_valid,
    input  wire tatf_pkg::tatf_reading_t i_raw,
    // trims
    input  wire logic [8:0]            i_offset_mag,
    input  wire logic                  i_offset_neg,
    input  wire logic [6:0]            i_gain_mag,
    input  wire logic                  i_gain_neg,
    // corrected reading
    output logic                       o_valid,
    output tatf_pkg::tatf_reading_t    o_value
);

    logic [18:0]        gain_product;
    logic signed [15:0] gain_adj;
    logic signed [15:0] offset_adj;
    logic signed [15:0] sum;
    tatf_pkg::tatf_reading_t value_next;

    // ----------------------------------------------------------------
    // correction arithmetic
    // ----------------------------------------------------------------
    always_comb begin
        gain_product = i_raw * i_gain_mag;
        gain_adj = {7'h00, gain_product[18:`TATF_GAIN_SHIFT]};
        if (i_gain_neg) begin // RQ6
            gain_adj = -gain_adj;
        end
        offset_adj = {7'h00, i_offset_mag}; // RQ2
        if (i_offset_neg) begin // RQ3
            offset_adj = -offset_adj;
        end
        sum = $signed({4'h0, i_raw}) + gain_adj + offset_adj; // RQ4 RQ5
        if (sum < 16'sh0000) begin
            value_next = 12'h000;
        end else if (sum > $signed({4'h0, `TATF_ADC_MAX})) begin
            value_next = `TATF_ADC_MAX;
        end else begin
            value_next = sum[11:0];
        end
    end

    // ----------------------------------------------------------------
    // output stage
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_valid <= 1'b0;
            o_value <= 12'h000;
        end else if (i_clock_enable) begin
            o_valid <= i_raw_valid;
            if (i_raw_valid) begin
                o_value <= value_next;
            end
        end
    end

endmodule : tatf_trim

// *** core/tatf_debounce.sv ***
// tatf_debounce: holds a fault flag back until its cause has lasted
// assumes: condition is a registered level on the same clock
`include "tatf_defs.svh"

module tatf_debounce #(
    parameter int unsigned CYCLES = 32'd4000000
) (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_reset,
    input  wire logic i_clock_enable,
    // condition and flag
    input  wire logic i_condition,
    output logic      o_flag
);

    tatf_pkg::tatf_db_state_t state_reg;
    logic [31:0]              count_reg;

    // ----------------------------------------------------------------
    // state and counter
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_reg <= tatf_pkg::TATF_DB_IDLE;
            count_reg <= 32'h0000_0000;
            o_flag    <= 1'b0;
        end else if (i_clock_enable) begin
            unique case (state_reg)
                tatf_pkg::TATF_DB_IDLE: begin
                    if (i_condition) begin
                        state_reg <= tatf_pkg::TATF_DB_COUNT;
                        count_reg <= 32'h0000_0001;
                    end
                end
                tatf_pkg::TATF_DB_COUNT: begin
                    if (!i_condition) begin // RQ12
                        state_reg <= tatf_pkg::TATF_DB_IDLE;
                        count_reg <= 32'h0000_0000;
                    end else if (count_reg >= CYCLES - 32'd1) begin // RQ9
                        state_reg <= tatf_pkg::TATF_DB_FAULT;
                        o_flag    <= 1'b1;
                    end else begin
                        count_reg <= count_reg + 32'h0000_0001;
                    end
                end
                tatf_pkg::TATF_DB_FAULT: begin
                    if (!i_condition) begin
                        state_reg <= tatf_pkg::TATF_DB_IDLE;
                        count_reg <= 32'h0000_0000;
                        o_flag    <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= tatf_pkg::TATF_DB_IDLE;
                    count_reg <= 32'h0000_0000;
                    o_flag    <= 1'b0;
                end
            endcase
        end
    end

endmodule : tatf_debounce

// *** sim/tatf_chk.sv ***
// tatf_chk: port-level checker for tatf_top
// assumes: bound into tatf_top at the foot
module tatf_chk #(
    parameter int unsigned DEBOUNCE_CYCLES = 32'd8
) (
    input wire logic                    i_clock,
    input wire logic                    i_reset,
    input wire logic                    i_clock_enable,
    input wire logic                    i_reg_write,
    input wire logic                    i_reg_read,
    input wire logic [15:0]             i_reg_addr,
    input wire logic [7:0]              i_reg_wdata,
    input wire logic [7:0]              o_reg_rdata,
    input wire logic                    o_reg_rvalid,
    input wire logic                    o_write_refused,
    input wire logic                    i_trim_unlock,
    input wire logic                    i_adc_valid,
    input wire tatf_pkg::tatf_reading_t i_adc_data,
    input wire logic                    o_temp_valid,
    input wire tatf_pkg::tatf_reading_t o_temp_value,
    input wire logic                    o_overtemp_fault
);
    logic [7:0]  thr_reg;
    logic [7:0]  hi_reg;
    logic [31:0] run_reg;
    logic        cond, trim_wr;

    assign cond = o_temp_value[11:3] < {thr_reg, 1'b0};
    assign trim_wr = i_reg_write && !i_trim_unlock &&
                     i_reg_addr >= 16'hFE16 && i_reg_addr <= 16'hFE18;

    // shadows of the threshold and the high offset trim
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            thr_reg <= 8'h00;
            hi_reg <= 8'h00;
        end else if (i_clock_enable && i_reg_write) begin
            if (i_reg_addr == 16'hFE19) begin
                thr_reg <= i_reg_wdata;
            end
            if (i_reg_addr == 16'hFE16 && i_trim_unlock) begin
                hi_reg <= i_reg_wdata;
            end
        end
    end

    // length of the current unbroken below-threshold run
    always_ff @(posedge i_clock) begin
        if (i_reset || !cond) begin
            run_reg <= 32'h0;
        end else if (i_clock_enable && run_reg != 32'hFFFFFFFF) begin
            run_reg <= run_reg + 32'h1;
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);

    sequence s_sample;
        i_clock_enable && i_adc_valid;
    endsequence
    sequence s_result;
        ##2 o_temp_valid;
    endsequence

    a_temp_latency: assert property (s_sample |-> s_result)
        else $error("reading late");
    a_locked_refuse: assert property (
        i_clock_enable && trim_wr |=> o_write_refused)
        else $error("write not refused");
    a_refuse_cause: assert property (
        o_write_refused |-> $past(trim_wr))
        else $error("stray refusal");
    a_thresh_readback: assert property (
        i_reg_read && i_reg_addr == 16'hFE19
        |=> o_reg_rvalid && o_reg_rdata == $past(thr_reg))
        else $error("threshold readback");
    a_high_readback: assert property (
        i_reg_read && i_reg_addr == 16'hFE16
        |=> o_reg_rdata == $past(hi_reg))
        else $error("high trim readback");
    a_rvalid_cause: assert property (
        o_reg_rvalid |-> $past(i_reg_read))
        else $error("stray read valid");
    a_fault_wait: assert property (
        $rose(o_overtemp_fault) |-> $past(run_reg, 2) >= DEBOUNCE_CYCLES)
        else $error("fault too early");
    a_fault_sets: assert property (
        run_reg >= DEBOUNCE_CYCLES + 2 |-> o_overtemp_fault)
        else $error("fault too late");
    a_fault_restart: assert property (
        !cond [*5] |-> !o_overtemp_fault)
        else $error("fault held");
endmodule : tatf_chk

bind tatf_top tatf_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_chk (
    .i_clock, .i_reset, .i_clock_enable, .i_reg_write, .i_reg_read,
    .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid,
    .o_write_refused, .i_trim_unlock, .i_adc_valid, .i_adc_data,
    .o_temp_valid, .o_temp_value, .o_overtemp_fault
);

// *** sim/tatf_sensor_model.sv ***
// tatf_sensor_model: converter that emits one reading every gap+1 cycles
// assumes: driven off the falling edge; data is not held between strobes
module tatf_sensor_model (
    input  wire logic                   i_clock,
    input  wire logic                   i_reset,
    input  wire logic [11:0]            i_level,
    input  wire logic [3:0]             i_gap,
    output logic                        o_adc_valid,
    output tatf_pkg::tatf_reading_t     o_adc_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] wait_reg;

    // between strobes the data lines toggle rather than hold
    always @(negedge i_clock) begin
        if (i_reset) begin
            o_adc_valid <= 1'b0;
            o_adc_data <= 12'h000;
            wait_reg <= 4'h0;
        end else if (wait_reg == 4'h0) begin
            o_adc_valid <= 1'b1;
            o_adc_data <= i_level;
            wait_reg <= i_gap;
        end else begin
            o_adc_valid <= 1'b0;
            o_adc_data <= ~o_adc_data;
            wait_reg <= wait_reg - 4'h1;
        end
    end
endmodule : tatf_sensor_model

// *** sim/testbench.sv ***
// testbench: registers, trims, lock and debounced fault of tatf_top
// assumes: sensor model supplies readings; debounce shortened to 8
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [7:0]  hi;
        logic [7:0]  lo;
        logic [7:0]  gain;
        logic [11:0] raw;
        logic [11:0] exp;
    } tatf_tb_row_t;

    logic                    i_clock, i_reset, i_clock_enable;
    logic                    i_reg_write, i_reg_read, i_trim_unlock;
    logic [15:0]             i_reg_addr;
    logic [7:0]              i_reg_wdata, o_reg_rdata, d;
    logic                    o_reg_rvalid, o_write_refused, refused;
    logic                    i_adc_valid, o_temp_valid, o_overtemp_fault;
    tatf_pkg::tatf_reading_t i_adc_data, o_temp_value;
    logic [11:0]             level;
    logic [3:0]              gap;
    int                      num_errors, compares;
    tatf_tb_row_t            rows [8] = '{
        '{8'h00, 8'h00, 8'h00, 12'h123, 12'h123},
        '{8'h00, 8'h10, 8'h00, 12'h100, 12'h110},
        '{8'h03, 8'h00, 8'h00, 12'h300, 12'h200},
        '{8'hA9, 8'h00, 8'h00, 12'h300, 12'h400},
        '{8'h00, 8'h00, 8'h40, 12'h400, 12'h440},
        '{8'h00, 8'h00, 8'hC0, 12'h400, 12'h3C0},
        '{8'h02, 8'hFF, 8'h00, 12'h010, 12'h000},
        '{8'h01, 8'hFF, 8'h00, 12'hF00, 12'hFFF}};

    tatf_top #(.DEBOUNCE_CYCLES(8)) dut (
        .i_clock, .i_reset, .i_clock_enable, .i_reg_write, .i_reg_read,
        .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid,
        .o_write_refused, .i_trim_unlock, .i_adc_valid, .i_adc_data,
        .o_temp_valid, .o_temp_value, .o_overtemp_fault);
    tatf_sensor_model u_sensor (.i_clock, .i_reset, .i_level(level),
        .i_gap(gap), .o_adc_valid(i_adc_valid), .o_adc_data(i_adc_data));

    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    task automatic finish_test;
        $display("compares %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge i_clock);
        i_reg_write = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = v;
        @(negedge i_clock);
        i_reg_write = 1'b0;
        refused = o_write_refused;
    endtask : wr

    task automatic rd(input logic [15:0] a);
        @(negedge i_clock);
        i_reg_read = 1'b1;
        i_reg_addr = a;
        @(negedge i_clock);
        i_reg_read = 1'b0;
        chk(o_reg_rvalid, 1'b1);
        d = o_reg_rdata;
    endtask : rd

    task automatic wait_valid(input int n);
        int seen = 0;
        for (int k = 0; k < 200 && seen < n; k++) begin
            @(negedge i_clock);
            if (o_temp_valid === 1'b1) seen++;
        end
        if (seen < n) begin
            num_errors++;
            finish_test();
        end
    endtask : wait_valid

    task automatic wait_fault(input logic v);
        for (int k = 0; k < 60; k++) begin
            @(negedge i_clock);
            if (o_overtemp_fault === v) return;
        end
        num_errors++;
        finish_test();
    endtask : wait_fault

    initial begin
        repeat (20000) @(posedge i_clock);
        num_errors++;
        finish_test();
    end

    initial begin
        {i_reg_write, i_reg_read, i_trim_unlock} = 3'h0;
        {i_reg_addr, i_reg_wdata, level} = 36'h0;
        {i_reset, i_clock_enable, gap} = 6'h33;
        {num_errors, compares} = 64'h0;
        repeat (16) @(negedge i_clock);
        i_reset = 1'b0;
        for (int a = 16'hFE16; a <= 16'hFE19; a++) begin
            rd(16'(a));
            chk(d, 8'h00);
        end
        $display("reset values done");
        i_trim_unlock = 1'b1;
        foreach (rows[i]) begin
            wr(16'hFE16, rows[i].hi);
            wr(16'hFE17, rows[i].lo);
            wr(16'hFE18, rows[i].gain);
            level = rows[i].raw;
            wait_valid(3);
            chk(o_temp_value, rows[i].exp);
            rd(16'hFE16);
            chk(d, rows[i].hi);
        end
        $display("trim rows done");
        i_trim_unlock = 1'b0;
        wr(16'hFE17, 8'h55);
        chk(refused, 1'b1);
        rd(16'hFE17);
        chk(d, 8'hFF);
        wr(16'hFE19, 8'h40);
        chk(refused, 1'b0);
        rd(16'h1234);
        chk(d, 8'h00);
        $display("lock test done");
        i_trim_unlock = 1'b1;
        for (int a = 16'hFE16; a <= 16'hFE18; a++) wr(16'(a), 8'h00);
        gap = 4'h0;
        level = 12'h3F8;
        wait_valid(2);
        chk(o_overtemp_fault, 1'b0);
        wait_fault(1'b1);
        chk(o_overtemp_fault, 1'b1);
        level = 12'h400;
        wait_fault(1'b0);
        chk(o_overtemp_fault, 1'b0);
        for (int j = 0; j < 6; j++) begin
            level = 12'h3F8;
            repeat (5) @(negedge i_clock);
            level = 12'h400;
            repeat (2) @(negedge i_clock);
        end
        chk(o_overtemp_fault, 1'b0);
        $display("debounce test done");
        wr(16'hFE19, 8'hFA);
        level = 12'hFA0;
        wait_valid(20);
        chk(o_overtemp_fault, 1'b0);
        level = 12'hF98;
        wait_fault(1'b1);
        chk(o_overtemp_fault, 1'b1);
        wr(16'hFE19, 8'h03);
        wait_fault(1'b0);
        level = 12'h028;
        wait_fault(1'b1);
        chk(o_overtemp_fault, 1'b1);
        rd(16'hFE1F);
        chk(d, 8'h01);
        $display("threshold range done");
        i_reset = 1'b1;
        repeat (2) @(negedge i_clock);
        i_reset = 1'b0;
        chk(o_overtemp_fault, 1'b0);
        rd(16'hFE19);
        chk(d, 8'h00);
        wait_valid(20);
        chk(o_overtemp_fault, 1'b0);
        i_clock_enable = 1'b0;
        wr(16'hFE19, 8'h77);
        i_clock_enable = 1'b1;
        rd(16'hFE19);
        chk(d, 8'h00);
        $display("mid-run reset done");
        finish_test();
    end
endmodule : testbench
